// File: core/rgca_global_ctl.v
// shared global control word with its primary view and receive-only alias
//
// Contract
// - alias write changes only bits four..zero
// - alias read returns whole shared word
// - receive reset independent of transmit reset
// - bits twelve..eight read transmit, ignore alias writes
// - reserved bits read zero, writes ignored
// - bit four runs receive frame sync
// - bit three runs receive state machine
// - bit two lets receive serializers operate
// - bit one runs receive fast divider
// - bit zero runs receive bit divider
`timescale 1ns/1ps
`default_nettype none
`include "rgca_consts.vh"

module rgca_global_ctl
(
    input  wire                         clk_sys,                  // register bus clock, 20 MHz
    input  wire                         rst_n,                    // async reset, active low
    input  wire [`RGCA_ADDR_W-1:0]      addr,                     // byte address
    input  wire [`RGCA_DATA_W-1:0]      wr_data,                  // write data
    input  wire                         wr_stb,                   // write strobe, one cycle
    input  wire                         rd_stb,                   // read strobe, one cycle
    output wire [`RGCA_DATA_W-1:0]      rd_data,                  // read data, cycle after strobe
    output wire [`RGCA_DATA_W-1:0]      shared_global_control_word, // live shared word
    output wire                         rx_framesync_gen_run,     // receive frame sync active
    output wire                         rx_state_machine_run,     // receive state machine released
    output wire                         rx_serializer_active,     // receive serializers operate
    output wire                         rx_hf_divider_run,        // receive fast divider runs
    output wire                         rx_bitclk_divider_run,    // receive bit divider runs
    output wire                         tx_framesync_gen_run,     // transmit frame sync active
    output wire                         tx_state_machine_run,     // transmit state machine released
    output wire                         tx_serializer_active,     // transmit serializers operate
    output wire                         tx_hf_divider_run,        // transmit fast divider runs
    output wire                         tx_bitclk_divider_run     // transmit bit divider runs
);

    // address match, used for both the write and the read decode
    function hit_at;
        input [`RGCA_ADDR_W-1:0] a;     // address on the bus
        input [`RGCA_ADDR_W-1:0] ofs;   // register offset
        begin
            hit_at = (a == ofs);
        end
    endfunction

    // decode of the two views
    wire                            hit_alias;     // receive-only alias view
    wire                            hit_primary;   // full primary view
    wire                            hit_any;       // any mapped register

    // section fields, the single copy of the state
    wire [`RGCA_FIELD_W-1:0]        rx_field_q;    // receive run bits
    wire [`RGCA_FIELD_W-1:0]        tx_field_q;    // transmit run bits

    // load controls for each field
    wire                            rx_wr_en;      // receive field load
    wire                            tx_wr_en;      // transmit field load
    wire [`RGCA_FIELD_W-1:0]        rx_wr_field;   // receive bits from the bus
    wire [`RGCA_FIELD_W-1:0]        tx_wr_field;   // transmit bits from the bus

    // assembled word seen by every reader
    wire [`RGCA_DATA_W-1:0]         word;

    assign hit_alias   = hit_at(addr, `RGCA_OFS_ALIAS);
    assign hit_primary = hit_at(addr, `RGCA_OFS_PRIMARY);
    assign hit_any     = hit_alias | hit_primary;

    // only bits 4..0 and 12..8 of the data are taken; the rest is dropped here so
    // that reserved bits cannot land anywhere, and tx_wr_en keeps the transmit
    // positions of an alias write out of the transmit field
    assign rx_wr_field = wr_data[`RGCA_RX_MSB:`RGCA_RX_LSB];
    assign tx_wr_field = wr_data[`RGCA_TX_MSB:`RGCA_TX_LSB];

    // either view may load the receive bits; they hit the same flops
    assign rx_wr_en = wr_stb & hit_any;

    // the transmit bits load only through the primary view: an alias write
    // leaves the transmit reset state alone
    assign tx_wr_en = wr_stb & hit_primary;

    // receive section run bits
    rgca_ctl_field u_rx_field
    (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .wr_en    (rx_wr_en),
        .wr_field (rx_wr_field),
        .field_q  (rx_field_q)
    );

    // transmit section run bits
    rgca_ctl_field u_tx_field
    (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .wr_en    (tx_wr_en),
        .wr_field (tx_wr_field),
        .field_q  (tx_field_q)
    );

    // the word: reserved positions are constant zero, transmit bits shown
    // read-only to the alias, receive bits shown live
    assign word = {`RGCA_RESV_HI_ZERO,
                   tx_field_q,
                   `RGCA_RESV_ZERO,
                   rx_field_q};

    // both views return the same word, so a read never depends on which
    // address last wrote the bits
    rgca_rd_port u_rd_port
    (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .rd_stb   (rd_stb),
        .rd_hit   (hit_any),
        .rd_word  (word),
        .rd_data_q (rd_data)
    );

    assign shared_global_control_word = word;

    // a zero holds the unit in reset, a one releases it; the unit logic
    // itself sits outside this bank and reads these levels directly
    assign rx_framesync_gen_run  = rx_field_q[`RGCA_BIT_FSG];
    assign rx_state_machine_run  = rx_field_q[`RGCA_BIT_SM];
    assign rx_serializer_active  = rx_field_q[`RGCA_BIT_SER];
    assign rx_hf_divider_run     = rx_field_q[`RGCA_BIT_HFDIV];
    assign rx_bitclk_divider_run = rx_field_q[`RGCA_BIT_BITCLK];

    // transmit levels come from their own field, untouched by alias writes
    assign tx_framesync_gen_run  = tx_field_q[`RGCA_BIT_FSG];
    assign tx_state_machine_run  = tx_field_q[`RGCA_BIT_SM];
    assign tx_serializer_active  = tx_field_q[`RGCA_BIT_SER];
    assign tx_hf_divider_run     = tx_field_q[`RGCA_BIT_HFDIV];
    assign tx_bitclk_divider_run = tx_field_q[`RGCA_BIT_BITCLK];

    // limitation: software that writes ones into reserved positions sees no
    // effect here, but a later revision may give them meaning

endmodule // rgca_global_ctl
`default_nettype wire

// File: core/rgca_consts.vh
// constants for the receive global control alias register bank
`ifndef RGCA_CONSTS_VH
`define RGCA_CONSTS_VH

// register bus geometry
`define RGCA_ADDR_W          8
`define RGCA_DATA_W          32

// byte offsets of the two views of the shared control word
`define RGCA_OFS_ALIAS       8'h60
`define RGCA_OFS_PRIMARY     8'h44

// width of one section's group of run bits
`define RGCA_FIELD_W         5

// receive field sits in bits 4..0
`define RGCA_RX_LSB          0
`define RGCA_RX_MSB          4

// transmit field sits in bits 12..8
`define RGCA_TX_LSB          8
`define RGCA_TX_MSB          12

// positions of each run bit inside a section field
`define RGCA_BIT_BITCLK      0
`define RGCA_BIT_HFDIV       1
`define RGCA_BIT_SER         2
`define RGCA_BIT_SM          3
`define RGCA_BIT_FSG         4

// reset values: every section held in reset
`define RGCA_FIELD_RST       5'h00
`define RGCA_WORD_RST        32'h0000_0000
`define RGCA_RESV_ZERO       3'h0
`define RGCA_RESV_HI_ZERO    19'h0_0000

`endif

// File: core/rgca_ctl_field.v
// five-bit field of run bits for one section of the shared control word
`timescale 1ns/1ps
`default_nettype none
`include "rgca_consts.vh"

module rgca_ctl_field
(
    input  wire                         clk_sys,   // register bus clock
    input  wire                         rst_n,     // async reset, active low
    input  wire                         wr_en,     // one-cycle load pulse
    input  wire [`RGCA_FIELD_W-1:0]     wr_field,  // value to load
    output reg  [`RGCA_FIELD_W-1:0]     field_q    // stored run bits
);

    wire [`RGCA_FIELD_W-1:0]            field_d;   // next value of the run bits

    // hold unless loaded; the flops take a value on every edge, so the hold
    // path is plain logic and no clock enable is needed
    assign field_d = wr_en ? wr_field : field_q;

    // the only storage of the section: every view of the word reads these flops
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            field_q <= `RGCA_FIELD_RST;    // all units held in reset
        end
        else
        begin
            field_q <= field_d;            // new run bits or the old ones
        end
    end

endmodule // rgca_ctl_field
`default_nettype wire

// File: core/rgca_rd_port.v
// registered read data stage for the control register bank
`timescale 1ns/1ps
`default_nettype none
`include "rgca_consts.vh"

module rgca_rd_port
(
    input  wire                         clk_sys,   // register bus clock
    input  wire                         rst_n,     // async reset, active low
    input  wire                         rd_stb,    // read strobe of the master
    input  wire                         rd_hit,    // address maps to a register
    input  wire [`RGCA_DATA_W-1:0]      rd_word,   // value to return on a hit
    output reg  [`RGCA_DATA_W-1:0]      rd_data_q  // answer, one cycle after strobe
);

    // data stand only in the cycle after the strobe; zero otherwise so that
    // a stale word never looks like a fresh answer
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data_q <= `RGCA_WORD_RST;
        end
        else if (rd_stb && rd_hit)
        begin
            rd_data_q <= rd_word;          // mapped register
        end
        else
        begin
            rd_data_q <= `RGCA_WORD_RST;   // idle or unmapped reads as zero
        end
    end

endmodule // rgca_rd_port
`default_nettype wire

// File: dv/rgca_chk.sv
// checker for the shared control word and its receive alias
`timescale 1ns/1ps
`default_nettype none
`include "rgca_consts.vh"
module rgca_chk
(
    input wire logic        clk_sys,                    // bus clock
    input wire logic        rst_n,                      // async reset, active low
    input wire logic [7:0]  addr,                       // byte address
    input wire logic [31:0] wr_data,                    // write data
    input wire logic        wr_stb,                     // write strobe
    input wire logic        rd_stb,                     // read strobe
    input wire logic [31:0] rd_data,                    // read answer
    input wire logic [31:0] shared_global_control_word, // live word
    input wire logic        rx_framesync_gen_run,       // receive run bits
    input wire logic        rx_state_machine_run,
    input wire logic        rx_serializer_active,
    input wire logic        rx_hf_divider_run,
    input wire logic        rx_bitclk_divider_run
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire [31:0] w = shared_global_control_word; // short alias
    // a write aimed at either view, and a mapped read
    sequence s_alias_wr; wr_stb && addr == `RGCA_OFS_ALIAS; endsequence
    sequence s_prim_wr; wr_stb && addr == `RGCA_OFS_PRIMARY; endsequence
    sequence s_map_rd; rd_stb && (addr == `RGCA_OFS_ALIAS || addr == `RGCA_OFS_PRIMARY);
    endsequence
    chk_alias_rx_load: assert property (s_alias_wr |=> w[4:0] == $past(wr_data[4:0]))
        else $error("alias write did not load receive bits");
    chk_alias_tx_keep: assert property (s_alias_wr |=> $stable(w[12:8]))
        else $error("alias write disturbed transmit bits");
    chk_prim_shared: assert property (
        s_prim_wr |=> w[12:0] == ($past(wr_data[12:0]) & 13'h1F1F))
        else $error("primary write not seen in shared word");
    chk_resv_zero: assert property (w[31:13] == 19'h0 && w[7:5] == 3'h0)
        else $error("reserved bits not zero");
    chk_read_word: assert property (s_map_rd |=> rd_data == $past(w))
        else $error("read did not return shared word");
    chk_read_idle: assert property (!rd_stb |=> rd_data == 32'h0)
        else $error("read data not zero when no answer due");
    chk_rx_levels: assert property (
        {rx_framesync_gen_run, rx_state_machine_run, rx_serializer_active,
        rx_hf_divider_run, rx_bitclk_divider_run} == w[4:0])
        else $error("receive run outputs differ from word");
    chk_unmapped_keep: assert property (
        wr_stb && addr != `RGCA_OFS_ALIAS && addr != `RGCA_OFS_PRIMARY |=> $stable(w))
        else $error("unmapped write changed word");
endmodule // rgca_chk
bind rgca_global_ctl rgca_chk chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .shared_global_control_word(shared_global_control_word),
    .rx_framesync_gen_run(rx_framesync_gen_run), .rx_state_machine_run(rx_state_machine_run),
    .rx_serializer_active(rx_serializer_active), .rx_hf_divider_run(rx_hf_divider_run),
    .rx_bitclk_divider_run(rx_bitclk_divider_run));
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench for the receive alias of the shared control word
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_sys = 1'h0;          // bus clock
    logic        rst_n   = 1'h0;          // async reset, active low
    logic        wr_stb  = 1'h0;          // write strobe
    logic        rd_stb  = 1'h0;          // read strobe
    logic        pend    = 1'h0;          // a read answer is due at this edge
    logic [7:0]  addr    = 8'h00;         // byte address
    logic [31:0] wr_data = 32'h0;         // write data
    logic [31:0] m       = 32'h0;         // expected shared word
    logic [31:0] qr[$];                   // expected read answers, oldest first
    logic [31:0] qs[$];                   // expected word at each answer, oldest first
    wire  [31:0] rd_data, w;              // design answers
    wire  [4:0]  rx, tx;                  // run bits, msb = frame sync
    int errors = 0, samples_checked = 0;
    always #25 clk_sys = ~clk_sys;        // 20 MHz
    rgca_global_ctl dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .shared_global_control_word(w),
        .rx_framesync_gen_run(rx[4]), .rx_state_machine_run(rx[3]),
        .rx_serializer_active(rx[2]), .rx_hf_divider_run(rx[1]), .rx_bitclk_divider_run(rx[0]),
        .tx_framesync_gen_run(tx[4]), .tx_state_machine_run(tx[3]),
        .tx_serializer_active(tx[2]), .tx_hf_divider_run(tx[1]), .tx_bitclk_divider_run(tx[0]));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one compare task for each kind of result
    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        cmp(got, exp);
    endtask
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        cmp(got, exp);
    endtask
    task automatic cmp_run(input logic [4:0] got, input logic [4:0] exp);
        cmp({27'h0, got}, {27'h0, exp});
    endtask
    task automatic conclude();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // one-cycle write; the model applies only what each view may change
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a; wr_data <= d; wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
        if (a == 8'h60) m[4:0] = d[4:0];
        if (a == 8'h44) m = d & 32'h1F1F;
    endtask
    // one-cycle read; unmapped places answer zero, the word is noted as well
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        addr <= a;
        rd_stb <= 1'h1;
        qr.push_back((a == 8'h60 || a == 8'h44) ? m : 32'h0);
        qs.push_back(m);
        @(posedge clk_sys);
        rd_stb <= 1'h0;
    endtask
    // monitor: the answer stands in the cycle after the strobe
    always @(posedge clk_sys)
    begin
        if (pend)
        begin
            cmp_rd(rd_data, qr.pop_front());
            cmp_word(w, qs[0]);
            cmp_run(rx, qs[0][4:0]);
            cmp_run(tx, qs[0][12:8]);
            qs.delete(0);
        end
        pend <= rd_stb;
    end
    // watchdog cuts a hang short
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        errors++;
        conclude();
    end
    initial
    begin
        logic [31:0] r;
        void'($urandom(32'h63CE9140));
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'h1;
        rd(8'h60);                          // reset value
        wr(8'h60, 32'hFFFFFFFF);            // reserved and tx ignored
        rd(8'h60);
        wr(8'h44, 32'h00001F00);            // tx set through primary view
        rd(8'h60);                          // tx visible through alias
        wr(8'h60, 32'h00000000);            // rx reset, reserved written zero
        rd(8'h44);                          // tx kept
        rd(8'h64);                          // unmapped read
        for (int i = 0; i < 200; i++)
        begin
            r = $urandom;
            case (r[1:0])
                2'h0: wr(8'h60, $urandom);
                2'h1: wr(8'h44, $urandom);
                2'h2: wr(r[15:8], $urandom);
                default: rd(r[2] ? 8'h60 : 8'h44);
            endcase
        end
        // mid-run reset returns every unit to its held state
        @(posedge clk_sys);
        rst_n <= 1'h0;
        m = 32'h0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'h1;
        rd(8'h60);                          // reset value again
        @(posedge clk_sys);
        @(posedge clk_sys);
        conclude();
    end
endmodule // testbench
`default_nettype wire
